// >>> verilog/csss_pkg.sv
// ============================================================
// shared constants of the supply start-up sequencer
package csss_pkg;
   // register port and line driver geometry
   localparam int unsigned ADDR_W  = 4;
   localparam int unsigned DATA_W  = 8;
   localparam int unsigned NUM_DRV = 8;

   // register offsets
   localparam logic [3:0] OFS_CTRL   = 4'h0;
   localparam logic [3:0] OFS_STATUS = 4'h1;

   // control register fields
   localparam int unsigned CTRL_PD_BIT   = 0;
   localparam int unsigned CTRL_TRI_BIT  = 1;
   localparam int unsigned CTRL_MODE_BIT = 2;
   localparam int unsigned CTRL_HDRM_BIT = 3;
   localparam logic [3:0]  CTRL_RESET    = 4'h0;

   // status register fields
   localparam int unsigned STAT_STATE_LSB = 0;
   localparam int unsigned STAT_NRDY_BIT  = 2;
   localparam int unsigned STAT_PD_BIT    = 3;
   localparam int unsigned STAT_BOOST_BIT = 4;

   // positions in the synchronised input vector
   localparam int unsigned SYN_W         = 16;
   localparam int unsigned SYN_HR_FULL   = 0;
   localparam int unsigned SYN_RES_FULL  = 1;
   localparam int unsigned SYN_HR_80     = 2;
   localparam int unsigned SYN_DRV_80    = 3;
   localparam int unsigned SYN_SUB_80    = 4;
   localparam int unsigned SYN_VBE_OK    = 5;
   localparam int unsigned SYN_PWD       = 6;
   localparam int unsigned SYN_LINE_LSB  = 7;
   localparam int unsigned SYN_SHUTTER   = 15;

   // sequencer states, gray along the start-up path
   typedef enum logic [1:0] {
      ST_OFF      = 2'b00,
      ST_CHG_HIGH = 2'b01,
      ST_CHG_RES  = 2'b11,
      ST_READY    = 2'b10
   } csss_state_t;
endpackage

// >>> verilog/csss_ccd_supply_startup_sequencer.sv
`timescale 1ns/1ps
module csss_ccd_supply_startup_sequencer
   import csss_pkg::*;
(
   // clock and reset
   input  wire logic                ref_clk,
   input  wire logic                rst_n,
   // register port
   input  wire logic [ADDR_W-1:0]   reg_addr,
   input  wire logic [DATA_W-1:0]   reg_wdata,
   input  wire logic                reg_wr,
   input  wire logic                reg_rd,
   output logic      [DATA_W-1:0]   reg_rdata,
   // analog comparator flags, asynchronous
   input  wire logic                high_rail_cap_full,
   input  wire logic                driver_reserve_cap_full,
   input  wire logic                high_rail_cap_above80,
   input  wire logic                driver_supply_above80,
   input  wire logic                substrate_supply_above80,
   input  wire logic                base_drive_voltage_ok,
   // device pins from the pattern generator
   input  wire logic                powerdown_pin,
   input  wire logic [NUM_DRV-1:0]  line_input,
   input  wire logic                shutter_input,
   // supply control and status
   output logic                     supplies_not_ready,
   output logic                     supplies_ok_flag,
   output logic                     high_rail_cap_chg_en,
   output logic                     driver_reserve_cap_chg_en,
   output logic                     negative_rail_conv_en,
   output logic                     base_drive_amplifier_boost,
   output logic                     regulator_mode2,
   output logic                     headroom_double_sel,
   output logic                     powered_down,
   // driver switch controls
   output logic      [NUM_DRV-1:0]  line_high_on,
   output logic      [NUM_DRV-1:0]  line_low_on,
   output logic      [NUM_DRV-1:0]  line_oe,
   output logic                     shutter_output
);

   // ============================================================
   // reset release
   logic rst_meta_r;
   logic rst_sync_n_r;

   // asynchronous assert, clocked release through two stages
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_meta_r   <= 1'b0;
         rst_sync_n_r <= 1'b0;
      end else begin
         rst_meta_r   <= 1'b1;
         rst_sync_n_r <= rst_meta_r;
      end
   end

   // ============================================================
   // state record
   typedef struct packed {
      logic [SYN_W-1:0]   syn1;
      logic [SYN_W-1:0]   syn2;
      csss_state_t        state;
      logic [3:0]         ctrl;
      logic               not_ready;
      logic               ok;
      logic               chg_high;
      logic               chg_res;
      logic               neg_en;
      logic               boost;
      logic               mode2;
      logic               headroom;
      logic               pdown;
      logic [NUM_DRV-1:0] hs;
      logic [NUM_DRV-1:0] ls;
      logic [NUM_DRV-1:0] oe;
      logic               sh_out;
      logic [DATA_W-1:0]  rdata;
   } csss_regs_t;

   csss_regs_t st_r;
   csss_regs_t st_nxt;

   // raw pins gathered for the synchroniser
   logic [SYN_W-1:0] raw_in;
   assign raw_in = {shutter_input, line_input, powerdown_pin, base_drive_voltage_ok,
                    substrate_supply_above80, driver_supply_above80,
                    high_rail_cap_above80, driver_reserve_cap_full, high_rail_cap_full};

   // synchronised views, only taken from the second stage
   logic               hr_full;
   logic               res_full;
   logic               hr_80;
   logic               drv_80;
   logic               sub_80;
   logic               vbe_ok;
   logic               pwd_pin;
   logic [NUM_DRV-1:0] line_in;
   logic               sh_in;
   assign hr_full  = st_r.syn2[SYN_HR_FULL];
   assign res_full = st_r.syn2[SYN_RES_FULL];
   assign hr_80    = st_r.syn2[SYN_HR_80];
   assign drv_80   = st_r.syn2[SYN_DRV_80];
   assign sub_80   = st_r.syn2[SYN_SUB_80];
   assign vbe_ok   = st_r.syn2[SYN_VBE_OK];
   assign pwd_pin  = st_r.syn2[SYN_PWD];
   assign line_in  = st_r.syn2[SYN_LINE_LSB +: NUM_DRV];
   assign sh_in    = st_r.syn2[SYN_SHUTTER];

   // ============================================================
   // next-state logic
   logic               pd_req;
   logic               rails_lost;
   logic [NUM_DRV-1:0] tgt_hs;
   logic [NUM_DRV-1:0] tgt_ls;
   logic               drv_en;

   always_comb begin
      st_nxt      = st_r;
      st_nxt.syn1 = raw_in;
      st_nxt.syn2 = st_r.syn1;

      // register writes; the port stays alive in power-down
      if (reg_wr && reg_addr == OFS_CTRL) begin
         st_nxt.ctrl = reg_wdata[3:0];
      end

      // pin or register bit; open pin is pulled low outside
      pd_req     = pwd_pin | st_r.ctrl[CTRL_PD_BIT];
      rails_lost = ~hr_80 | ~drv_80 | ~sub_80;

      // sequencer
      case (st_r.state)
         ST_OFF: begin
            st_nxt.state = ST_CHG_HIGH;
         end
         ST_CHG_HIGH: begin
            if (hr_full) begin
               st_nxt.state = ST_CHG_RES;
            end
         end
         ST_CHG_RES: begin
            if (!hr_80) begin
               st_nxt.state = ST_CHG_HIGH;
            end else if (hr_full && res_full && drv_80 && sub_80) begin
               st_nxt.state = ST_READY;
            end
         end
         ST_READY: begin
            if (rails_lost) begin
               st_nxt.state = ST_CHG_HIGH;
            end
         end
         default: begin
            st_nxt.state = ST_OFF;
         end
      endcase
      // power-down always wins and restarts the cycle later
      if (pd_req) begin
         st_nxt.state = ST_OFF;
      end

      // flags derived from the coming state so they agree at all times
      st_nxt.pdown     = pd_req;
      st_nxt.not_ready = (st_nxt.state != ST_READY);
      st_nxt.ok        = (st_nxt.state == ST_READY);
      st_nxt.chg_high  = (st_nxt.state != ST_OFF);
      st_nxt.chg_res   = (st_nxt.state == ST_CHG_RES) ||
                         (st_nxt.state == ST_READY);
      // negative rail follows power only, never the sequencer
      st_nxt.neg_en    = ~pd_req;
      st_nxt.mode2     = st_r.ctrl[CTRL_MODE_BIT];
      st_nxt.headroom  = st_r.ctrl[CTRL_HDRM_BIT];

      // amplifier current limit
      st_nxt.boost = ~pd_req &
                     ((st_nxt.not_ready & ~vbe_ok) |
                      (st_nxt.ok & st_r.ctrl[CTRL_MODE_BIT]));

      // line drivers: invert input, tri-state unless ready and not forced
      drv_en    = st_nxt.ok & ~st_r.ctrl[CTRL_TRI_BIT];
      tgt_hs    = drv_en ? ~line_in : '0;
      tgt_ls    = drv_en ? line_in : '0;
      // a switch closes only once its partner was open a full cycle
      st_nxt.hs = tgt_hs & ~st_r.ls;
      st_nxt.ls = tgt_ls & ~st_r.hs;
      st_nxt.oe = st_nxt.hs | st_nxt.ls;
      st_nxt.sh_out = ~sh_in;

      // read data stand for one cycle only
      st_nxt.rdata = '0;
      if (reg_rd) begin
         case (reg_addr)
            OFS_CTRL: begin
               st_nxt.rdata = {4'h0, st_r.ctrl};
            end
            OFS_STATUS: begin
               st_nxt.rdata = {3'h0, st_r.boost, st_r.pdown, st_r.not_ready, st_r.state};
            end
            default: begin
               st_nxt.rdata = '0;
            end
         endcase
      end
   end

   // ============================================================
   // state register
   always_ff @(posedge ref_clk or negedge rst_sync_n_r) begin
      if (!rst_sync_n_r) begin
         st_r           <= '0;
         st_r.state     <= ST_OFF;
         st_r.ctrl      <= CTRL_RESET;
         st_r.not_ready <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ============================================================
   // outputs straight from the state register
   assign reg_rdata                  = st_r.rdata;
   assign supplies_not_ready         = st_r.not_ready;
   assign supplies_ok_flag           = st_r.ok;
   assign high_rail_cap_chg_en       = st_r.chg_high;
   assign driver_reserve_cap_chg_en  = st_r.chg_res;
   assign negative_rail_conv_en      = st_r.neg_en;
   assign base_drive_amplifier_boost = st_r.boost;
   assign regulator_mode2            = st_r.mode2;
   assign headroom_double_sel        = st_r.headroom;
   assign powered_down               = st_r.pdown;
   assign line_high_on               = st_r.hs;
   assign line_low_on                = st_r.ls;
   assign line_oe                    = st_r.oe;
   assign shutter_output             = st_r.sh_out;

   // ============================================================
   // checks
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_sync_n_r);

   sequence s_all_good;
      hr_full && res_full && drv_80 && sub_80 && !pd_req;
   endsequence
   sequence s_charging_res;
      st_r.state == ST_CHG_RES;
   endsequence

   a_pin_flag_inverse: assert property (supplies_ok_flag == !supplies_not_ready)
      else $error("ok flag not inverse of not-ready pin");
   a_ready_needs_rails: assert property ($fell(supplies_not_ready) |->
      $past(hr_full) && $past(res_full) && $past(drv_80) && $past(sub_80))
      else $error("ready without all rails good");
   a_rail_drop_restart: assert property (!supplies_not_ready &&
      (!hr_80 || !drv_80 || !sub_80) |=> supplies_not_ready)
      else $error("rail loss did not restart start-up");
   a_reserve_after_high: assert property (driver_reserve_cap_chg_en |-> high_rail_cap_chg_en)
      else $error("reserve rail charging before high rail");
   a_res_to_ready: assert property (s_charging_res ##0 s_all_good |=> supplies_ok_flag)
      else $error("ready not reached with all rails good");
   a_tristate_startup: assert property (!supplies_ok_flag |-> line_oe == '0)
      else $error("line driver enabled while not ready");
   a_tristate_forced: assert property (st_r.ctrl[CTRL_TRI_BIT] |=> line_oe == '0)
      else $error("forced tri-state ignored");
   a_no_shoot_through: assert property ((line_high_on & line_low_on) == '0)
      else $error("both switches of a driver on");
   a_dead_gap: assert property ((($past(line_high_on) & line_low_on) == '0) &&
      (($past(line_low_on) & line_high_on) == '0))
      else $error("missing break-before-make gap");
   a_driver_inverts: assert property (line_high_on[0] |-> !$past(line_in[0]))
      else $error("driver output not inverse of input");
   // first edge after release still shows reset values, so skip it
   a_boost_startup: assert property ($past(rst_sync_n_r) && supplies_not_ready &&
      !powered_down && !$past(vbe_ok) |-> base_drive_amplifier_boost)
      else $error("no boost during start-up");
   a_boost_mode2: assert property (supplies_ok_flag |->
      base_drive_amplifier_boost == $past(st_r.ctrl[CTRL_MODE_BIT]))
      else $error("boost wrong after start-up");
   // negative rail follows the request with the same one-edge delay
   a_powerdown_off: assert property (pd_req |=> powered_down &&
      supplies_not_ready && !high_rail_cap_chg_en && !negative_rail_conv_en)
      else $error("power-down did not stop sequencer");
   a_shutter_inverts: assert property ($past(rst_sync_n_r) |->
      shutter_output == !$past(sh_in))
      else $error("shutter output not inverse of input");

endmodule

// >>> testbench/csss_ppg_model.sv
`timescale 1ns/1ps
// ============================================================
// pattern generator model feeding the driver input pins
module csss_ppg_model (
   // clock
   input  wire logic       ref_clk,
   // commands from the bench
   input  wire logic [7:0] pat,
   input  wire logic       sh_cmd,
   input  wire logic       pd_req,
   // device pins
   output logic      [7:0] line_input,
   output logic            shutter_input,
   output logic            powerdown_pin
);
   // pins change just after the edge, as a real generator output does
   always @(posedge ref_clk) begin
      line_input    <= pat;
      shutter_input <= sh_cmd;
   end
   // quiet pins until the first edge
   initial begin
      line_input    = 8'h00;
      shutter_input = 1'b0;
   end
   // a released pin falls to the pull-down level
   assign powerdown_pin = pd_req ? 1'b1 : 1'b0;
endmodule

// >>> testbench/tb.sv
`timescale 1ns/1ps
// ============================================================
// self-checking bench of the supply start-up sequencer
module tb;
   import csss_pkg::*;
   // clock, reset, register port
   logic                ref_clk = 1'b0;
   logic                rst_n = 1'b0;
   logic [ADDR_W-1:0]   reg_addr = '0;
   logic [DATA_W-1:0]   reg_wdata = '0;
   logic                reg_wr = 1'b0;
   logic                reg_rd = 1'b0;
   logic [DATA_W-1:0]   reg_rdata, rd;
   // comparators, bit 5 down to 0: base ok, sub80, drv80, hr80, res full, hr full
   logic [5:0]          cmp = 6'h00;
   logic [NUM_DRV-1:0]  pat = 8'h00;
   logic                sh_cmd = 1'b0;
   logic                pd_req = 1'b0;
   // pins and outputs
   logic [NUM_DRV-1:0]  line_input, hs, ls, oe;
   logic                shutter_input, powerdown_pin, nrdy, ok, chg_hi, chg_res;
   logic                neg_en, boost, mode2, hdrm, pdn, sh_out;
   int                  bad_count = 0;
   int                  checked = 0;

   // 20 MHz clock
   always #25 ref_clk = ~ref_clk;

   csss_ccd_supply_startup_sequencer i_csss_ccd_supply_startup_sequencer (
      .ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .high_rail_cap_full(cmp[0]), .driver_reserve_cap_full(cmp[1]),
      .high_rail_cap_above80(cmp[2]), .driver_supply_above80(cmp[3]),
      .substrate_supply_above80(cmp[4]), .base_drive_voltage_ok(cmp[5]),
      .powerdown_pin(powerdown_pin), .line_input(line_input),
      .shutter_input(shutter_input), .supplies_not_ready(nrdy), .supplies_ok_flag(ok),
      .high_rail_cap_chg_en(chg_hi), .driver_reserve_cap_chg_en(chg_res),
      .negative_rail_conv_en(neg_en), .base_drive_amplifier_boost(boost),
      .regulator_mode2(mode2), .headroom_double_sel(hdrm), .powered_down(pdn),
      .line_high_on(hs), .line_low_on(ls), .line_oe(oe), .shutter_output(sh_out));

   csss_ppg_model i_csss_ppg_model (
      .ref_clk(ref_clk), .pat(pat), .sh_cmd(sh_cmd), .pd_req(pd_req),
      .line_input(line_input), .shutter_input(shutter_input),
      .powerdown_pin(powerdown_pin));

   // ============================================================
   // compare, wait and bus helpers
   task automatic chk_bit(input string nm, input logic e, input logic g);
      checked++;
      if (g !== e) begin
         bad_count++;
         $display("ERROR %s expected %b seen %b", nm, e, g);
      end
   endtask
   task automatic chk_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
      checked++;
      if (g !== e) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // outputs are judged on the falling edge, well clear of updates
   task automatic cyc(input int n);
      repeat (n) @(negedge ref_clk);
   endtask
   // bounded wait; a hang ends the run
   task automatic wait_nrdy(input logic v);
      for (int i = 0; i < 60 && nrdy !== v; i++)
         cyc(1);
      chk_bit("supplies_not_ready", v, nrdy);
      if (nrdy !== v)
         tally_and_finish;
   endtask
   task automatic set_cmp(input logic [5:0] v);
      @(posedge ref_clk);
      cmp <= v;
   endtask
   // write leaves two edges so derived outputs have landed
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
      cyc(2);
   endtask
   task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
      @(posedge ref_clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      @(negedge ref_clk);
      d = reg_rdata;
   endtask

   // ============================================================
   // scenarios
   task automatic t_start;
      chk_bit("ok", 1'b0, ok);
      chk_byte("line_oe", 8'h00, oe);
      chk_bit("boost", 1'b1, boost);
      chk_bit("chg_hi", 1'b1, chg_hi);
      chk_bit("chg_res", 1'b0, chg_res);
      chk_bit("neg_en", 1'b1, neg_en);
      rd_reg(OFS_STATUS, rd);
      chk_byte("status", 8'h15, rd);
      set_cmp(6'h05);
      cyc(4);
      chk_bit("chg_res", 1'b1, chg_res);
      set_cmp(6'h0f);
      cyc(6);
      chk_bit("supplies_not_ready", 1'b1, nrdy);
      set_cmp(6'h1f);
      wait_nrdy(1'b0);
      chk_bit("ok", 1'b1, ok);
      rd_reg(OFS_STATUS, rd);
      chk_byte("status", 8'h02, rd);
      $display("test start-up done");
   endtask
   // a polarity change must pass through one both-off cycle
   task automatic t_drive(input logic [7:0] p, input logic s);
      logic [7:0] both, gap, old;
      old  = pat;
      both = 8'h00;
      gap  = 8'hff;
      @(posedge ref_clk);
      pat    <= p;
      sh_cmd <= s;
      repeat (8) begin
         @(negedge ref_clk);
         both |= hs & ls;
         gap  &= oe;
      end
      chk_byte("hs and ls overlap", 8'h00, both);
      chk_byte("dead gap", ~(old ^ p), gap);
      chk_byte("line_high_on", ~p, hs);
      chk_byte("line_low_on", p, ls);
      chk_bit("shutter_output", ~s, sh_out);
      $display("test drive %h done", p);
   endtask
   task automatic t_regs;
      wr(OFS_CTRL, 8'h02);
      chk_byte("line_oe", 8'h00, oe);
      chk_bit("supplies_not_ready", 1'b0, nrdy);
      wr(OFS_CTRL, 8'h0c);
      chk_byte("line_oe", 8'hff, oe);
      chk_bit("mode2", 1'b1, mode2);
      chk_bit("hdrm", 1'b1, hdrm);
      chk_bit("boost", 1'b1, boost);
      wr(OFS_CTRL, 8'hf8);
      wr(4'h2, 8'hff);
      rd_reg(OFS_CTRL, rd);
      chk_byte("ctrl", 8'h08, rd);
      chk_bit("mode2", 1'b0, mode2);
      chk_bit("boost", 1'b0, boost);
      rd_reg(4'h2, rd);
      chk_byte("unmapped", 8'h00, rd);
      wr(OFS_CTRL, 8'h00);
      chk_bit("hdrm", 1'b0, hdrm);
      $display("test registers done");
   endtask
   task automatic t_drop;
      logic [5:0] m [3] = '{6'h1a, 6'h17, 6'h2f};
      foreach (m[i]) begin
         set_cmp(m[i]);
         wait_nrdy(1'b1);
         cyc(2);
         chk_bit("ok", 1'b0, ok);
         chk_byte("line_oe", 8'h00, oe);
         chk_bit("boost", ~m[i][5], boost);
         set_cmp(6'h1f);
         wait_nrdy(1'b0);
      end
      $display("test rail drop done");
   endtask
   task automatic t_pwd;
      @(posedge ref_clk);
      pd_req <= 1'b1;
      cyc(5);
      chk_bit("powered_down", 1'b1, pdn);
      chk_bit("neg_en", 1'b0, neg_en);
      chk_byte("line_oe", 8'h00, oe);
      rd_reg(OFS_STATUS, rd);
      chk_byte("status", 8'h0c, rd);
      @(posedge ref_clk);
      pd_req <= 1'b0;
      wait_nrdy(1'b0);
      chk_bit("neg_en", 1'b1, neg_en);
      wr(OFS_CTRL, 8'h01);
      chk_bit("powered_down", 1'b1, pdn);
      rd_reg(OFS_CTRL, rd);
      chk_byte("ctrl", 8'h01, rd);
      wr(OFS_CTRL, 8'h00);
      wait_nrdy(1'b0);
      $display("test power-down done");
   endtask

   // main sequence, reset held for eight cycles
   initial begin
      repeat (8) @(posedge ref_clk);
      rst_n <= 1'b1;
      cyc(6);
      t_start;
      cyc(3);
      t_drive(8'h0f, 1'b1);
      t_drive(8'hf0, 1'b0);
      t_drive(8'ha5, 1'b1);
      t_drive(8'ha5, 1'b0);
      t_regs;
      t_drop;
      t_pwd;
      tally_and_finish;
   end
endmodule
